/* File: verilog/hwi_pkg.sv */
// Purpose: Shared constants and carriers for the counter event interrupts
// Assumes: One clock domain, AHB-Lite register access
// Notes:   Event index i is delivered as event type i+1
package hwi_pkg;

  localparam int          NUM_EVT       = 10;
  localparam int          VAL_W         = 32;

  // Event indices, type number is index plus one
  localparam int          EV_GATE_OPEN  = 0;
  localparam int          EV_GATE_CLOSE = 1;
  localparam int          EV_OVERFLOW   = 2;
  localparam int          EV_UNDERFLOW  = 3;
  localparam int          EV_CMP0       = 4;
  localparam int          EV_CMP1       = 5;
  localparam int          EV_ZERO       = 6;
  localparam int          EV_CAPTURE    = 7;
  localparam int          EV_SYNC       = 8;
  localparam int          EV_DIR        = 9;

  // Register byte offsets
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;
  localparam logic [7:0]  ADDR_CLEAR    = 8'h08;
  localparam logic [7:0]  ADDR_IRQ_EN   = 8'h0C;
  localparam logic [7:0]  ADDR_DIAG     = 8'h10;

  // Field positions
  localparam int          CTRL_MODE_BIT = 16;
  localparam int          CTRL_IDX_BIT  = 17;
  localparam int          CTRL_DI_BIT   = 18;
  localparam int          DIAG_LOST_BIT = 0;
  localparam int          DIAG_CODE_LSB = 8;
  localparam int          DIAG_DIR_BIT  = 16;
  localparam int          DIAG_TYPE_LSB = 24;

  // Reset values
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam logic [9:0]  STATUS_RESET  = 10'h000;
  localparam logic [9:0]  IRQ_EN_RESET  = 10'h000;
  localparam logic [9:0]  PEND_RESET    = 10'h000;
  localparam logic [3:0]  TYPE_RESET    = 4'h0;
  localparam logic        DIR_RESET     = 1'b0;

  localparam logic [7:0]  LOST_CODE     = 8'h16;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } hwi_st_e;

  // Event inputs from the counting datapath, same clock
  typedef struct packed {
    logic                    gate;
    logic                    ovf;
    logic                    unf;
    logic                    cmp0;
    logic                    cmp1;
    logic                    by_pulse;
    logic                    capture;
    logic                    value_upd;
    logic signed [VAL_W-1:0] value;
  } hwi_evt_s;

  // Register write from the bus front end
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] data;
  } hwi_wr_s;

endpackage

/* File: verilog/hwi_ahb_slave.sv */
// Purpose: AHB-Lite front end for the event interrupt registers
// Assumes: Single word transfers, zero wait states
// Notes:   Read data is captured in the address phase
`timescale 1ns/1ps
module hwi_ahb_slave (
  input  wire logic           hclk,
  input  wire logic           hresetn,
  input  wire logic           hsel,
  input  wire logic [31:0]    haddr,
  input  wire logic [1:0]     htrans,
  input  wire logic           hwrite,
  input  wire logic [2:0]     hsize,
  input  wire logic [31:0]    hwdata,
  input  wire logic           hready,
  output logic                hreadyout,
  output logic                hresp,
  output logic [31:0]         hrdata,
  output logic [7:0]          rd_addr,
  input  wire logic [31:0]    rd_data,
  output hwi_pkg::hwi_wr_s    wr
);

  logic       take;
  logic       ph_wr;
  logic [7:0] ph_addr;

  // Sub-word transfers are ignored rather than half-applied
  assign take      = hsel & hready & htrans[1] & (hsize == 3'h2);
  assign rd_addr   = haddr[7:0];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr        = '{wr: ph_wr, addr: ph_addr, data: hwdata};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr   <= 1'b0;
      ph_addr <= 8'h00;
    end else begin
      ph_wr   <= take & hwrite;
      ph_addr <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata <= rd_data;
    end
  end

endmodule

/* File: verilog/hwi_top.sv */
// Purpose: Counter event detection and hardware interrupt delivery
// Assumes: Datapath events on hclk; index and sync pins asynchronous
// Notes:   One interrupt in flight; lost report holds until CTRL write
//
// Added by the designer: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module hwi_top (
  input  wire logic            hclk,
  input  wire logic            hresetn,
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic                 hreadyout,
  output logic                 hresp,
  output logic [31:0]          hrdata,
  input  hwi_pkg::hwi_evt_s    evt,
  input  wire logic            index_mark_pin,
  input  wire logic            sync_digital_input,
  output logic                 hw_irq_req,
  output logic [3:0]           hw_irq_type,
  input  wire logic            hw_irq_ack,
  output logic                 lost_diag,
  output logic                 direction_feedback_bit,
  output logic                 irq
);

  localparam int N = hwi_pkg::NUM_EVT;

  function automatic logic [N-1:0] lowest_one(input logic [N-1:0] v);
    lowest_one = v & N'(~v + N'(1));
  endfunction

  function automatic logic [3:0] type_of(input logic [N-1:0] oh);
    type_of = 4'h0;
    for (int i = 0; i < N; i++) begin
      if (oh[i]) begin
        type_of = 4'(i + 1);
      end
    end
  endfunction

  hwi_pkg::hwi_wr_s   wr;
  logic [7:0]         rd_addr;
  logic [31:0]        rd_data;
  logic [31:0]        ctrl;
  logic [N-1:0]       status;
  logic [N-1:0]       irq_en;
  logic [N-1:0]       clr;
  logic [N-1:0]       hw_en;
  logic [N-1:0]       ev;
  logic [N-1:0]       hw_ev;
  logic [N-1:0]       pend;
  logic [N-1:0]       next_pend;
  logic [N-1:0]       cur_oh;
  logic [N-1:0]       launch_oh;
  logic               launch;
  logic               lost_now;
  logic               ctrl_wr;
  hwi_pkg::hwi_st_e   st;
  logic               gate_q;
  logic               idx_s1;
  logic               idx_s2;
  logic               idx_s3;
  logic               di_s1;
  logic               di_s2;
  logic               di_s3;
  logic               idx_rise;
  logic               di_rise;
  logic signed [31:0] val_q;
  logic               seen_change;
  logic               moved;
  logic               new_dir;

  hwi_ahb_slave u_bus (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data),
    .wr        (wr)
  );

  // Register decode
  assign ctrl_wr = wr.wr && (wr.addr == hwi_pkg::ADDR_CTRL);

  always_comb begin
    clr = '0;
    if (wr.wr && (wr.addr == hwi_pkg::ADDR_CLEAR)) begin
      clr = wr.data[N-1:0];
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (rd_addr)
      hwi_pkg::ADDR_CTRL: begin
        rd_data = ctrl;
      end
      hwi_pkg::ADDR_STATUS: begin
        rd_data[N-1:0] = status;
      end
      hwi_pkg::ADDR_IRQ_EN: begin
        rd_data[N-1:0] = irq_en;
      end
      hwi_pkg::ADDR_DIAG: begin
        rd_data[hwi_pkg::DIAG_LOST_BIT] = lost_diag;
        if (lost_diag) begin
          rd_data[hwi_pkg::DIAG_CODE_LSB +: 8] = hwi_pkg::LOST_CODE;
        end
        rd_data[hwi_pkg::DIAG_DIR_BIT]       = direction_feedback_bit;
        rd_data[hwi_pkg::DIAG_TYPE_LSB +: 4] = hw_irq_type;
      end
      default: begin
        rd_data = 32'h0000_0000;
      end
    endcase
  end

  // Capture enable is dropped unless counting mode is written with it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= hwi_pkg::CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl <= wr.data;
      ctrl[hwi_pkg::EV_CAPTURE] <= wr.data[hwi_pkg::EV_CAPTURE]
                                 & wr.data[hwi_pkg::CTRL_MODE_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_en <= hwi_pkg::IRQ_EN_RESET;
    end else if (wr.wr && (wr.addr == hwi_pkg::ADDR_IRQ_EN)) begin
      irq_en <= wr.data[N-1:0];
    end
  end

  assign hw_en = ctrl[N-1:0];

  // Pins pass two flops before any edge logic
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idx_s1 <= 1'b0;
      idx_s2 <= 1'b0;
      idx_s3 <= 1'b0;
      di_s1  <= 1'b0;
      di_s2  <= 1'b0;
      di_s3  <= 1'b0;
    end else begin
      idx_s1 <= index_mark_pin;
      idx_s2 <= idx_s1;
      idx_s3 <= idx_s2;
      di_s1  <= sync_digital_input;
      di_s2  <= di_s1;
      di_s3  <= di_s2;
    end
  end

  assign idx_rise = idx_s2 & ~idx_s3;
  assign di_rise  = di_s2 & ~di_s3;

  // Value history for zero crossing and direction
  assign moved   = evt.value_upd && (evt.value != val_q);
  assign new_dir = evt.value < val_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate_q                 <= 1'b0;
      val_q                  <= '0;
      seen_change            <= 1'b0;
      direction_feedback_bit <= hwi_pkg::DIR_RESET;
    end else begin
      gate_q <= evt.gate;
      if (moved) begin
        val_q                  <= evt.value;
        seen_change            <= 1'b1;
        direction_feedback_bit <= new_dir;
      end
    end
  end

  // Event detection
  always_comb begin
    ev                         = '0;
    ev[hwi_pkg::EV_GATE_OPEN]  = evt.gate & ~gate_q;
    ev[hwi_pkg::EV_GATE_CLOSE] = ~evt.gate & gate_q;
    ev[hwi_pkg::EV_OVERFLOW]   = evt.ovf;
    ev[hwi_pkg::EV_UNDERFLOW]  = evt.unf;
    ev[hwi_pkg::EV_CMP0]       = evt.cmp0 & evt.by_pulse;
    ev[hwi_pkg::EV_CMP1]       = evt.cmp1 & evt.by_pulse;
    ev[hwi_pkg::EV_ZERO]       = moved & (evt.value[31] != val_q[31]);
    ev[hwi_pkg::EV_CAPTURE]    = evt.capture;
    ev[hwi_pkg::EV_SYNC]       = (idx_rise & ctrl[hwi_pkg::CTRL_IDX_BIT])
                               | (di_rise & ctrl[hwi_pkg::CTRL_DI_BIT]);
    // No previous change means no direction to reverse from
    ev[hwi_pkg::EV_DIR]        = moved & seen_change
                               & (new_dir != direction_feedback_bit);
  end

  assign hw_ev = ev & hw_en;

  // Sticky status, set wins over clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status <= hwi_pkg::STATUS_RESET;
    end else begin
      status <= (status & ~clr) | ev;
    end
  end

  assign irq = |(status & irq_en);

  // Delivery to the processor
  assign launch    = (st == hwi_pkg::ST_IDLE) && (|pend);
  assign launch_oh = launch ? lowest_one(pend) : '0;
  // A lost event is dropped, so it never arrives late as a second interrupt
  assign next_pend = (pend & ~launch_oh) | (hw_ev & ~(pend | cur_oh));
  // Same type still pending or in flight cannot be delivered again
  assign lost_now  = |(hw_ev & (pend | cur_oh));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend <= hwi_pkg::PEND_RESET;
    end else begin
      pend <= next_pend;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st          <= hwi_pkg::ST_IDLE;
      cur_oh      <= '0;
      hw_irq_type <= hwi_pkg::TYPE_RESET;
    end else begin
      unique case (st)
        hwi_pkg::ST_IDLE: begin
          if (launch) begin
            st          <= hwi_pkg::ST_WAIT;
            cur_oh      <= launch_oh;
            hw_irq_type <= type_of(launch_oh);
          end
        end
        hwi_pkg::ST_WAIT: begin
          if (hw_irq_ack) begin
            st     <= hwi_pkg::ST_IDLE;
            cur_oh <= '0;
          end
        end
      endcase
    end
  end

  assign hw_irq_req = (st == hwi_pkg::ST_WAIT);

  // Lost report stays until new parameters; a loss wins over the write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lost_diag <= 1'b0;
    end else if (lost_now) begin
      lost_diag <= 1'b1;
    end else if (ctrl_wr) begin
      lost_diag <= 1'b0;
    end
  end

  a_gate_open: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $rose(evt.gate) |-> ev[hwi_pkg::EV_GATE_OPEN]
  ) else $error("gate opening missed");

  a_gate_close: assert property (
    @(posedge hclk) disable iff (!hresetn)
    $fell(evt.gate) |-> ev[hwi_pkg::EV_GATE_CLOSE]
  ) else $error("gate closing missed");

  a_ovf_pend: assert property (
    @(posedge hclk) disable iff (!hresetn)
    evt.ovf && hw_en[hwi_pkg::EV_OVERFLOW]
    && !cur_oh[hwi_pkg::EV_OVERFLOW] && !launch_oh[hwi_pkg::EV_OVERFLOW]
    |=> pend[hwi_pkg::EV_OVERFLOW]
  ) else $error("overflow not pending");

  a_unf_pend: assert property (
    @(posedge hclk) disable iff (!hresetn)
    evt.unf && hw_en[hwi_pkg::EV_UNDERFLOW]
    && !cur_oh[hwi_pkg::EV_UNDERFLOW] && !launch_oh[hwi_pkg::EV_UNDERFLOW]
    |=> pend[hwi_pkg::EV_UNDERFLOW]
  ) else $error("underflow not pending");

  a_cmp_suppress: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !evt.by_pulse |-> !ev[hwi_pkg::EV_CMP0] && !ev[hwi_pkg::EV_CMP1]
  ) else $error("comparison without count pulse");

  a_zero_cross: assert property (
    @(posedge hclk) disable iff (!hresetn)
    evt.value_upd && (evt.value[31] != val_q[31])
    |-> ev[hwi_pkg::EV_ZERO]
  ) else $error("zero crossing missed");

  a_capture_mode: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !ctrl[hwi_pkg::CTRL_MODE_BIT] |-> !hw_en[hwi_pkg::EV_CAPTURE]
  ) else $error("capture enabled outside counting mode");

  a_first_dir: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !seen_change |-> !ev[hwi_pkg::EV_DIR]
  ) else $error("reversal flagged on first change");

  a_lost_flag: assert property (
    @(posedge hclk) disable iff (!hresetn)
    hw_ev[hwi_pkg::EV_OVERFLOW] && hw_irq_req
    && (hw_irq_type == 4'h3) |=> lost_diag
  ) else $error("lost interrupt not reported");

  a_lost_drop: assert property (
    @(posedge hclk) disable iff (!hresetn)
    hw_ev[hwi_pkg::EV_OVERFLOW] && cur_oh[hwi_pkg::EV_OVERFLOW]
    |=> !pend[hwi_pkg::EV_OVERFLOW]
  ) else $error("lost interrupt queued again");

  a_hold_pending: assert property (
    @(posedge hclk) disable iff (!hresetn)
    hw_irq_req && !hw_irq_ack |=> hw_irq_req && $stable(hw_irq_type)
  ) else $error("interrupt dropped before ack");

  a_launch_next: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !hw_irq_req && (|pend)
    |=> hw_irq_req && (hw_irq_type == type_of(lowest_one($past(pend))))
  ) else $error("pending type not delivered");

endmodule

/* File: verif/hwi_host_model.sv */
// Purpose: Processor side that takes and acknowledges hardware interrupts
// Assumes: Same clock as the device, ack sampled while request stands
// Notes:   Hold stalls the ack so the device sees an unanswered interrupt
`timescale 1ns/1ps
module hwi_host_model (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       hw_irq_req,
  input  wire logic [3:0] hw_irq_type,
  input  wire logic       hold,
  input  wire logic [2:0] delay,
  output logic            hw_irq_ack,
  output logic            got,
  output logic [3:0]      got_type
);
  logic [2:0] cnt;
  logic       busy;

  // One ack per request; busy waits for the request to drop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hw_irq_ack <= 1'b0;
      got        <= 1'b0;
      got_type   <= 4'h0;
      cnt        <= 3'h0;
      busy       <= 1'b0;
    end else begin
      hw_irq_ack <= 1'b0;
      got        <= 1'b0;
      if (!hw_irq_req) begin
        cnt  <= 3'h0;
        busy <= 1'b0;
      end else if (!busy && !hold) begin
        if (cnt >= delay) begin
          hw_irq_ack <= 1'b1;
          got        <= 1'b1;
          got_type   <= hw_irq_type;
          busy       <= 1'b1;
        end else begin
          cnt <= cnt + 3'h1;
        end
      end
    end
  end
endmodule

/* File: verif/hwi_top_tb.sv */
// Purpose: Self-checking bench for the counter event interrupts
// Assumes: Zero wait AHB-Lite slave, host model acks every interrupt
// Notes:   Expected types queue in order of delivery, lowest index first
`timescale 1ns/1ps
module hwi_top_tb;
  logic              hclk    = 1'b0;
  logic              hresetn = 1'b0;
  logic              hsel    = 1'b0;
  logic [31:0]       haddr   = 32'h0;
  logic [31:0]       hwdata  = 32'h0;
  logic [1:0]        htrans  = 2'h0;
  logic              hwrite  = 1'b0;
  logic [2:0]        hsize   = 3'h2;
  logic              hold    = 1'b0;
  logic [2:0]        delay   = 3'h0;
  logic              idx_pin = 1'b0;
  logic              di_pin  = 1'b0;
  hwi_pkg::hwi_evt_s ev;
  logic              hreadyout;
  logic              hresp;
  logic [31:0]       hrdata;
  logic              req;
  logic [3:0]        typ;
  logic              ack;
  logic              lost;
  logic              dir;
  logic              irq;
  logic              got;
  logic [3:0]        got_type;
  logic [31:0]       rd;
  logic [31:0]       st      = 32'h0000_9F99;
  int                miscompares = 0;
  int                cmp_count   = 0;
  int                exp_q[$];

  always #2.5 hclk = ~hclk;

  hwi_top u_hwi_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .evt(ev), .index_mark_pin(idx_pin),
    .sync_digital_input(di_pin), .hw_irq_req(req), .hw_irq_type(typ),
    .hw_irq_ack(ack), .lost_diag(lost), .direction_feedback_bit(dir),
    .irq(irq));

  hwi_host_model u_hwi_host_model (.hclk(hclk), .hresetn(hresetn),
    .hw_irq_req(req), .hw_irq_type(typ), .hold(hold), .delay(delay),
    .hw_irq_ack(ack), .got(got), .got_type(got_type));

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  // Read data is taken at the edge that ends the data phase
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic drain();
    for (int i = 0; i < 80 && exp_q.size() != 0; i++) @(posedge hclk);
    repeat (4) @(posedge hclk);
    chk(exp_q.size(), 0, "interrupt missing");
  endtask

  // Kind 6 is a value update; kinds 0 and 1 set the gate level; other kinds pulse one event source
  task automatic fire(input int k, input int v, input int t1, input int t2);
    st = xs(st);
    delay <= st[2:0];
    if (t1 > 0) exp_q.push_back(t1);
    if (t2 > 0) exp_q.push_back(t2);
    case (k)
      0: ev.gate <= 1'b1;
      1: ev.gate <= 1'b0;
      2: ev.ovf <= 1'b1;
      3: ev.unf <= 1'b1;
      4: ev.cmp0 <= 1'b1;
      5: ev.cmp1 <= 1'b1;
      6: begin
        ev.value     <= v;
        ev.value_upd <= 1'b1;
      end
      7: ev.capture <= 1'b1;
      8: idx_pin <= 1'b1;
      default: di_pin <= 1'b1;
    endcase
    @(posedge hclk);
    ev.ovf       <= 1'b0;
    ev.unf       <= 1'b0;
    ev.cmp0      <= 1'b0;
    ev.cmp1      <= 1'b0;
    ev.capture   <= 1'b0;
    ev.value_upd <= 1'b0;
    repeat (4) @(posedge hclk);
    idx_pin <= 1'b0;
    di_pin  <= 1'b0;
    if (!hold) drain();
  endtask

  always @(posedge hclk) begin
    if (got === 1'b1) begin
      if (exp_q.size() == 0) chk(got_type, 4'hF, "unexpected irq");
      else chk(got_type, exp_q.pop_front(), "irq type");
    end
  end

  initial begin
    repeat (20000) @(posedge hclk);
    miscompares++;
    end_of_test();
  end

  initial begin
    ev = '0;
    ev.by_pulse = 1'b1;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, hwi_pkg::ADDR_CTRL, 32'h0, rd);
    chk(rd, hwi_pkg::CTRL_RESET, "ctrl reset");
    ahb(1'b0, hwi_pkg::ADDR_DIAG, 32'h0, rd);
    chk(rd, 32'h0, "diag reset");
    ahb(1'b0, 8'h20, 32'h0, rd);
    chk(rd, 32'h0, "unmapped read");
    chk(hresp, 1'b0, "okay response");
    chk(dir, 1'b0, "direction reset");
    ahb(1'b1, hwi_pkg::ADDR_CTRL, 32'h0007_03FF, rd);
    ahb(1'b1, hwi_pkg::ADDR_IRQ_EN, 32'h0000_03FF, rd);
    fire(0, 0, 1, 0);
    fire(1, 0, 2, 0);
    fire(2, 0, 3, 0);
    fire(3, 0, 4, 0);
    fire(4, 0, 5, 0);
    fire(5, 0, 6, 0);
    fire(7, 0, 8, 0);
    fire(8, 0, 9, 0);
    fire(9, 0, 9, 0);
    fire(6, 10, 0, 0);
    fire(6, 20, 0, 0);
    fire(6, 15, 10, 0);
    chk(dir, 1'b1, "direction down");
    fire(6, -3, 7, 0);
    fire(6, 4, 7, 10);
    chk(dir, 1'b0, "direction up");
    ahb(1'b0, hwi_pkg::ADDR_STATUS, 32'h0, rd);
    chk(rd, (1 << hwi_pkg::NUM_EVT) - 1, "status sticky");
    chk(irq, 1'b1, "irq raised");
    ahb(1'b1, hwi_pkg::ADDR_IRQ_EN, 32'h0, rd);
    // The write settles only after the edge that ends the data phase
    @(posedge hclk);
    chk(irq, 1'b0, "irq masked");
    ahb(1'b1, hwi_pkg::ADDR_CLEAR, 32'h0000_03FF, rd);
    ahb(1'b0, hwi_pkg::ADDR_STATUS, 32'h0, rd);
    chk(rd, 32'h0, "status cleared");
    ahb(1'b1, hwi_pkg::ADDR_IRQ_EN, 32'h0000_0004, rd);
    fire(2, 0, 3, 0);
    chk(irq, 1'b1, "irq enabled bit");
    ahb(1'b1, hwi_pkg::ADDR_CLEAR, 32'h0000_0004, rd);
    @(posedge hclk);
    chk(irq, 1'b0, "irq clear");
    ev.by_pulse <= 1'b0;
    fire(4, 0, 0, 0);
    fire(5, 0, 0, 0);
    ev.by_pulse <= 1'b1;
    ahb(1'b1, hwi_pkg::ADDR_CTRL, 32'h0000_03FF, rd);
    ahb(1'b0, hwi_pkg::ADDR_CTRL, 32'h0, rd);
    chk(rd, 32'h0000_037F, "capture enable outside mode");
    fire(7, 0, 0, 0);
    hold <= 1'b1;
    fire(2, 0, 3, 0);
    fire(2, 0, 0, 0);
    chk(lost, 1'b1, "lost flag");
    ahb(1'b0, hwi_pkg::ADDR_DIAG, 32'h0, rd);
    chk(rd, 32'h0300_1601, "lost code");
    hold <= 1'b0;
    drain();
    ahb(1'b1, hwi_pkg::ADDR_CTRL, 32'h0000_037F, rd);
    @(posedge hclk);
    chk(lost, 1'b0, "lost cleared");
    end_of_test();
  end
endmodule
